// ==== src/lpl_trip_thresholds.sv ====
// Purpose: startup bias search, trip comparator ranging and transmit power trip thresholds
// Assumes: power feedback arrives as an 8-bit code on the power loop full scale
// Notes: trip voltage = full scale / 255 * code, so code compare equals voltage compare
`timescale 1ns/1ps
module lpl_trip_thresholds #(
  parameter int SETTLE = lpl_pkg::SETTLE_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // password state from the access block
  input wire logic i_upper_password,
  input wire logic i_lower_password,
  input wire logic i_table_rw_enable,
  input wire logic i_table_read_enable,
  // loop inputs
  input wire logic [7:0] i_power_loop_dac_value,
  input wire logic [7:0] i_power_feedback_input,
  input wire logic i_tx_disable,
  input wire logic i_bias_over_ceiling,
  // loop outputs
  output logic [8:0] o_bias_setting,
  output logic o_startup_busy,
  output logic [2:0] o_bias_range,
  output logic [2:0] o_power_loop_range,
  output logic [7:0] o_high_trip_code,
  output logic [7:0] o_low_trip_code,
  // alarms and interrupt
  output logic o_transmit_power_high_alarm,
  output logic o_transmit_power_low_alarm,
  output logic o_bias_max_alarm,
  output logic o_irq
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_STEP = 4'h2,
    ST_SEARCH = 4'h4,
    ST_RUN = 4'h8
  } lpl_state_e;

  lpl_state_e state_reg;
  logic [7:0] range_reg;
  logic [7:0] step_reg;
  logic [7:0] high_margin_reg;
  logic [7:0] low_margin_reg;
  logic [8:0] ceiling_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic [8:0] bias_reg;
  logic [8:0] delta_reg;
  logic [15:0] settle_reg;
  logic [7:0] fb_meta_reg, fb_sync_reg;
  logic [2:0] txd_sync_reg;
  logic [1:0] ovr_sync_reg;

  // synchronisers for pins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fb_meta_reg <= 8'h00;
      fb_sync_reg <= 8'h00;
      txd_sync_reg <= 3'h0;
      ovr_sync_reg <= 2'h0;
    end else if (i_ce) begin
      fb_meta_reg <= i_power_feedback_input;
      fb_sync_reg <= fb_meta_reg;
      txd_sync_reg <= {txd_sync_reg[1:0], i_tx_disable};
      ovr_sync_reg <= {ovr_sync_reg[0], i_bias_over_ceiling};
    end
  end

  // access qualification
  logic upper_ok, cfg_wr_ok, cfg_rd_ok;
  assign upper_ok = i_upper_password;
  assign cfg_wr_ok = i_upper_password | (i_lower_password & i_table_rw_enable);
  assign cfg_rd_ok = cfg_wr_ok | (i_lower_password & i_table_read_enable);

  logic wr_ce, rd_ce;
  assign wr_ce = i_ce & i_wr;
  assign rd_ce = i_ce & i_rd;

  // nonvolatile configuration bytes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      range_reg <= lpl_pkg::NV_FACTORY_DEFAULT;
      step_reg <= lpl_pkg::NV_FACTORY_DEFAULT;
      high_margin_reg <= lpl_pkg::NV_FACTORY_DEFAULT;
      low_margin_reg <= lpl_pkg::NV_FACTORY_DEFAULT;
      ceiling_reg <= {1'b0, lpl_pkg::NV_FACTORY_DEFAULT};
      mask_reg <= lpl_pkg::MASK_RESET[3:0];
    end else if (wr_ce) begin
      if (i_addr == lpl_pkg::ADDR_TRIP_COMPARATOR_RANGE && upper_ok) begin
        range_reg <= i_wr_data & lpl_pkg::RANGE_WRITE_MASK;
      end
      if (cfg_wr_ok) begin
        if (i_addr == lpl_pkg::ADDR_STARTUP_BIAS_STEP) begin
          step_reg <= i_wr_data;
        end
        if (i_addr == lpl_pkg::ADDR_HIGH_POWER_TRIP_MARGIN) begin
          high_margin_reg <= i_wr_data;
        end
        if (i_addr == lpl_pkg::ADDR_LOW_POWER_TRIP_MARGIN) begin
          low_margin_reg <= i_wr_data;
        end
        if (i_addr == lpl_pkg::ADDR_BIAS_CEILING_LO) begin
          ceiling_reg[7:0] <= i_wr_data;
        end
        if (i_addr == lpl_pkg::ADDR_BIAS_CEILING_HI) begin
          ceiling_reg[8] <= i_wr_data[0];
        end
      end
      if (i_addr == lpl_pkg::ADDR_EVENT_MASK) begin
        mask_reg <= i_wr_data[3:0];
      end
    end
  end

  // range outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bias_range <= 3'h0;
      o_power_loop_range <= 3'h0;
    end else if (i_ce) begin
      o_bias_range <= range_reg[lpl_pkg::BIAS_RANGE_LSB +: lpl_pkg::RANGE_W];
      o_power_loop_range <= range_reg[lpl_pkg::POWER_LOOP_RANGE_LSB +: lpl_pkg::RANGE_W];
    end
  end

  // trip codes with saturation
  logic [8:0] high_sum;
  logic [8:0] low_diff;
  logic [7:0] high_code, low_code;
  assign high_sum = {1'b0, i_power_loop_dac_value} + {1'b0, high_margin_reg};
  assign low_diff = {1'b0, i_power_loop_dac_value} - {1'b0, low_margin_reg};
  assign high_code = high_sum[8] ? lpl_pkg::TRIP_CODE_MAX : high_sum[7:0];
  assign low_code = low_diff[8] ? lpl_pkg::TRIP_CODE_MIN : low_diff[7:0];

  logic tx_high, tx_low, bias_max;
  assign tx_high = fb_sync_reg > high_code;
  assign tx_low = fb_sync_reg < low_code;
  assign bias_max = (state_reg == ST_RUN) & ovr_sync_reg[1];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_high_trip_code <= lpl_pkg::TRIP_CODE_MIN;
      o_low_trip_code <= lpl_pkg::TRIP_CODE_MIN;
      o_transmit_power_high_alarm <= 1'b0;
      o_transmit_power_low_alarm <= 1'b0;
      o_bias_max_alarm <= 1'b0;
    end else if (i_ce) begin
      o_high_trip_code <= high_code;
      o_low_trip_code <= low_code;
      o_transmit_power_high_alarm <= tx_high;
      o_transmit_power_low_alarm <= tx_low;
      o_bias_max_alarm <= bias_max;
    end
  end

  // startup search
  logic txd_pulse_end, settled;
  logic [9:0] step_sum;
  logic [8:0] step_inc;
  logic [9:0] search_up;
  logic [8:0] search_dn;
  assign txd_pulse_end = txd_sync_reg[2] & ~txd_sync_reg[1];
  assign settled = settle_reg == 16'h0000;
  assign step_inc = {step_reg, 1'b1};
  assign step_sum = {1'b0, bias_reg} + {1'b0, step_inc};
  assign search_up = {1'b0, bias_reg} + {1'b0, delta_reg};
  assign search_dn = (bias_reg > delta_reg) ? (bias_reg - delta_reg) : lpl_pkg::BIAS_RESET;

  logic above_ref;
  assign above_ref = fb_sync_reg > i_power_loop_dac_value;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      bias_reg <= lpl_pkg::BIAS_RESET;
      delta_reg <= lpl_pkg::SEARCH_DELTA_MIN;
      settle_reg <= 16'h0000;
    end else if (i_ce) begin
      if (!settled) begin
        settle_reg <= settle_reg - 16'h0001;
      end
      if (txd_pulse_end) begin
        state_reg <= ST_IDLE;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            bias_reg <= lpl_pkg::BIAS_RESET;
            settle_reg <= 16'(SETTLE);
            state_reg <= ST_STEP;
          end
          ST_STEP: begin
            if (settled) begin
              if (above_ref || step_sum > {1'b0, ceiling_reg}) begin
                delta_reg <= (step_inc[8:1] == 8'h00) ? lpl_pkg::SEARCH_DELTA_MIN
                           : {1'b0, step_inc[8:1]};
                state_reg <= ST_SEARCH;
              end else begin
                bias_reg <= step_sum[8:0];
                settle_reg <= 16'(SETTLE);
              end
            end
          end
          ST_SEARCH: begin
            if (settled) begin
              if (above_ref) begin
                bias_reg <= search_dn;
              end else if (search_up[9] || search_up[8:0] > ceiling_reg) begin
                bias_reg <= ceiling_reg;
              end else begin
                bias_reg <= search_up[8:0];
              end
              settle_reg <= 16'(SETTLE);
              if (delta_reg <= lpl_pkg::SEARCH_DELTA_MIN) begin
                state_reg <= ST_RUN;
              end else begin
                delta_reg <= delta_reg >> 1;
              end
            end
          end
          ST_RUN: begin
            state_reg <= ST_RUN;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bias_setting <= lpl_pkg::BIAS_RESET;
      o_startup_busy <= 1'b0;
    end else if (i_ce) begin
      o_bias_setting <= bias_reg;
      o_startup_busy <= state_reg != ST_RUN;
    end
  end

  // sticky events, cleared by a status read, set wins
  logic [3:0] events;
  logic search_done;
  assign search_done = (state_reg == ST_SEARCH) & settled & (delta_reg <= lpl_pkg::SEARCH_DELTA_MIN);
  always_comb begin
    events = 4'h0;
    events[lpl_pkg::EV_TX_HIGH] = tx_high;
    events[lpl_pkg::EV_TX_LOW] = tx_low;
    events[lpl_pkg::EV_BIAS_MAX] = bias_max;
    events[lpl_pkg::EV_STARTUP_DONE] = search_done;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_reg <= 4'h0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      if (i_rd && i_addr == lpl_pkg::ADDR_EVENT_STATUS) begin
        status_reg <= events;
      end else begin
        status_reg <= status_reg | events;
      end
      o_irq <= |(status_reg & mask_reg);
    end
  end

  // read port
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= lpl_pkg::READ_UNMAPPED;
    end else if (rd_ce) begin
      o_rd_data <= lpl_pkg::READ_UNMAPPED;
      unique case (i_addr)
        lpl_pkg::ADDR_TRIP_COMPARATOR_RANGE: begin
          if (upper_ok) begin
            o_rd_data <= range_reg;
          end
        end
        lpl_pkg::ADDR_RESERVED_BYTE: begin
          o_rd_data <= lpl_pkg::NV_FACTORY_DEFAULT;
        end
        lpl_pkg::ADDR_STARTUP_BIAS_STEP: begin
          if (cfg_rd_ok) begin
            o_rd_data <= step_reg;
          end
        end
        lpl_pkg::ADDR_HIGH_POWER_TRIP_MARGIN: begin
          if (cfg_rd_ok) begin
            o_rd_data <= high_margin_reg;
          end
        end
        lpl_pkg::ADDR_LOW_POWER_TRIP_MARGIN: begin
          if (cfg_rd_ok) begin
            o_rd_data <= low_margin_reg;
          end
        end
        lpl_pkg::ADDR_BIAS_CEILING_LO: begin
          if (cfg_rd_ok) begin
            o_rd_data <= ceiling_reg[7:0];
          end
        end
        lpl_pkg::ADDR_BIAS_CEILING_HI: begin
          if (cfg_rd_ok) begin
            o_rd_data <= {7'h00, ceiling_reg[8]};
          end
        end
        lpl_pkg::ADDR_EVENT_STATUS: begin
          o_rd_data <= {4'h0, status_reg};
        end
        lpl_pkg::ADDR_EVENT_MASK: begin
          o_rd_data <= {4'h0, mask_reg};
        end
        lpl_pkg::ADDR_BIAS_LO: begin
          o_rd_data <= bias_reg[7:0];
        end
        lpl_pkg::ADDR_LOOP_STATE: begin
          o_rd_data <= {3'h0, state_reg, bias_reg[8]};
        end
        default: begin
          o_rd_data <= lpl_pkg::READ_UNMAPPED;
        end
      endcase
    end
  end

endmodule : lpl_trip_thresholds

// ==== src/lpl_pkg.sv ====
// Purpose: shared constants for the laser power loop trip threshold block
// Assumes: 8-bit register port, byte-wide registers
// Notes: nonvolatile bytes modelled as flops reset to their factory value
package lpl_pkg;
  // register offsets
  localparam logic [7:0] ADDR_TRIP_COMPARATOR_RANGE = 8'hB9;
  localparam logic [7:0] ADDR_RESERVED_BYTE = 8'hBA;
  localparam logic [7:0] ADDR_STARTUP_BIAS_STEP = 8'hBB;
  localparam logic [7:0] ADDR_HIGH_POWER_TRIP_MARGIN = 8'hBC;
  localparam logic [7:0] ADDR_LOW_POWER_TRIP_MARGIN = 8'hBD;
  localparam logic [7:0] ADDR_BIAS_CEILING_LO = 8'hF0;
  localparam logic [7:0] ADDR_BIAS_CEILING_HI = 8'hF1;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'hF2;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'hF3;
  localparam logic [7:0] ADDR_BIAS_LO = 8'hF4;
  localparam logic [7:0] ADDR_LOOP_STATE = 8'hF5;
  // reset and factory values
  localparam logic [7:0] NV_FACTORY_DEFAULT = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // comparator ranging fields
  localparam int BIAS_RANGE_LSB = 4;
  localparam int POWER_LOOP_RANGE_LSB = 0;
  localparam int RANGE_W = 3;
  localparam logic [7:0] RANGE_WRITE_MASK = 8'h77;
  // event status bits
  localparam int EV_TX_HIGH = 0;
  localparam int EV_TX_LOW = 1;
  localparam int EV_BIAS_MAX = 2;
  localparam int EV_STARTUP_DONE = 3;
  localparam int EV_W = 4;
  // bias and threshold arithmetic
  localparam int BIAS_W = 9;
  localparam logic [7:0] TRIP_CODE_MAX = 8'hFF;
  localparam logic [7:0] TRIP_CODE_MIN = 8'h00;
  localparam logic [8:0] BIAS_RESET = 9'h000;
  localparam logic [8:0] SEARCH_DELTA_MIN = 9'h001;
  // settling time between bias steps
  localparam int SETTLE_NS = 1000;
  localparam int CLK_NS = 20;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage : lpl_pkg

// ==== test/lpl_tt_props.sv ====
// Purpose: port checker for the trip threshold block
// Assumes: no checked traffic while clock enable is low
// Notes: bound to the design at the foot
`timescale 1ns/1ps
module lpl_tt_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rd_data,
  input wire logic i_upper_password,
  // loop
  input wire logic [7:0] i_power_loop_dac_value,
  input wire logic [7:0] i_power_feedback_input,
  input wire logic i_tx_disable,
  input wire logic o_startup_busy,
  input wire logic [2:0] o_bias_range,
  input wire logic [2:0] o_power_loop_range,
  input wire logic [7:0] o_high_trip_code,
  input wire logic [7:0] o_low_trip_code,
  input wire logic o_transmit_power_high_alarm,
  input wire logic o_transmit_power_low_alarm,
  input wire logic o_bias_max_alarm
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rng_wr(pw);
    i_wr && i_addr == lpl_pkg::ADDR_TRIP_COMPARATOR_RANGE && i_upper_password == pw ##1 !i_wr;
  endsequence
  range_write_a: assert property (
    s_rng_wr(1'b1) |-> ##1 {o_bias_range, o_power_loop_range} ==
      {$past(i_wr_data[6:4], 2), $past(i_wr_data[2:0], 2)}) else $error("range not loaded");
  range_deny_a: assert property (
    s_rng_wr(1'b0) |-> ##1 $stable({o_bias_range, o_power_loop_range}))
    else $error("range write not refused");
  reserved_read_a: assert property (
    i_rd && i_addr == lpl_pkg::ADDR_RESERVED_BYTE |=> o_rd_data == 8'h00)
    else $error("reserved byte not zero");
  bias_alarm_a: assert property (
    o_startup_busy && $past(o_startup_busy) |-> !o_bias_max_alarm)
    else $error("bias alarm during startup");
  restart_a: assert property (
    $fell(i_tx_disable) |-> ##[1:8] o_startup_busy) else $error("no restart");
  high_code_a: assert property (
    $stable(i_power_loop_dac_value) [*4] |-> o_high_trip_code >= i_power_loop_dac_value)
    else $error("high code below dac");
  low_code_a: assert property (
    $stable(i_power_loop_dac_value) [*4] |-> o_low_trip_code <= i_power_loop_dac_value)
    else $error("low code above dac");
  high_alarm_a: assert property (
    (i_power_feedback_input > o_high_trip_code && $stable(o_high_trip_code)) [*7]
      |-> o_transmit_power_high_alarm) else $error("high alarm missing");
  low_alarm_a: assert property (
    (i_power_feedback_input < o_low_trip_code && $stable(o_low_trip_code)) [*7]
      |-> o_transmit_power_low_alarm) else $error("low alarm missing");
endmodule : lpl_tt_props
bind lpl_trip_thresholds lpl_tt_props lpl_tt_props_inst (.*);

// ==== test/lpl_laser_model.sv ====
// Purpose: laser driver and monitor photodiode stand-in
// Assumes: feedback code follows bias at half scale, no lag
// Notes: bench may force feedback and set the ceiling compare
`timescale 1ns/1ps
module lpl_laser_model (
  // bias from the loop
  input wire logic [8:0] i_bias,
  // bench controls
  input wire logic [8:0] i_force,
  input wire logic [8:0] i_ceiling,
  // pins to the loop
  output logic [7:0] o_feedback,
  output logic o_over_ceiling
);
  assign o_feedback = i_force[8] ? i_force[7:0] : i_bias[8:1];
  assign o_over_ceiling = i_bias > i_ceiling;
endmodule : lpl_laser_model

// ==== test/lpl_trip_thresholds_tb_top.sv ====
// Purpose: self-checking bench for the trip threshold block
// Assumes: settle count cut to 4, clock enable dropped once near the end
// Notes: registers mirrored in an associative array model
`timescale 1ns/1ps
module lpl_trip_thresholds_tb_top;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_tx_disable = 1'b0, up = 1'b0, lo = 1'b0, trw = 1'b0, trd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, dac = 8'h00;
  logic [7:0] i_power_feedback_input, o_rd_data, o_high_trip_code, o_low_trip_code;
  logic [8:0] o_bias_setting, frc = 9'h000, ceil = 9'h1FF;
  logic [2:0] o_bias_range, o_power_loop_range;
  logic i_bias_over_ceiling, o_startup_busy, o_transmit_power_high_alarm;
  logic o_transmit_power_low_alarm, o_bias_max_alarm, o_irq;
  logic [31:0] seed = 32'h00006B67;
  int failures = 0, check_count = 0;
  int mdl[int];
  lpl_trip_thresholds #(.SETTLE(4)) lpl_trip_thresholds_inst (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rd_data(o_rd_data),
    .i_upper_password(up),
    .i_lower_password(lo),
    .i_table_rw_enable(trw),
    .i_table_read_enable(trd),
    .i_power_loop_dac_value(dac),
    .i_power_feedback_input(i_power_feedback_input),
    .i_tx_disable(i_tx_disable),
    .i_bias_over_ceiling(i_bias_over_ceiling),
    .o_bias_setting(o_bias_setting),
    .o_startup_busy(o_startup_busy),
    .o_bias_range(o_bias_range),
    .o_power_loop_range(o_power_loop_range),
    .o_high_trip_code(o_high_trip_code),
    .o_low_trip_code(o_low_trip_code),
    .o_transmit_power_high_alarm(o_transmit_power_high_alarm),
    .o_transmit_power_low_alarm(o_transmit_power_low_alarm),
    .o_bias_max_alarm(o_bias_max_alarm),
    .o_irq(o_irq));
  lpl_laser_model lpl_laser_model_inst (.i_bias(o_bias_setting), .i_force(frc),
    .i_ceiling(ceil), .o_feedback(i_power_feedback_input), .o_over_ceiling(i_bias_over_ceiling));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic bit can(input logic [7:0] a, input bit w);
    if (a == 8'hB9) return up;
    if (a >= 8'hBB && a <= 8'hBD) return up || (lo && (trw || (!w && trd)));
    return 1'b0;
  endfunction : can
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    d = o_rd_data;
  endtask : bus_rd
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (o_startup_busy !== lvl && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      $display("Error at %0t: startup wait ran out", $time);
      complete_run();
    end
  endtask : wait_busy
  initial begin
    logic [7:0] a, r;
    logic [31:0] e;
    int i, m;
    for (i = 8'hB9; i <= 8'hBD; i++) mdl[i] = 0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    up <= 1'b1;
    for (i = 8'hB9; i <= 8'hBD; i++) begin
      bus_rd(i[7:0], r);
      chk(r, 9'h000);
    end
    for (i = 0; i < 60; i++) begin
      e = rnd();
      {up, lo, trw, trd} <= e[3:0];
      a = (e[6:4] > 3'd4) ? 8'h10 : 8'hB9 + e[6:4];
      if (e[24]) dac <= e[23:16];
      if (e[7]) begin
        bus_wr(a, e[15:8]);
        if (can(a, 1'b1)) mdl[a] = (a == 8'hB9) ? (e[15:8] & 8'h77) : e[15:8];
      end else begin
        bus_rd(a, r);
        chk(r, can(a, 1'b0) ? 9'(mdl[a]) : 9'h000);
      end
      repeat (3) @(posedge i_clk);
      m = dac + mdl[8'hBC];
      chk(o_high_trip_code, (m > 255) ? 9'h0FF : 9'(m));
      m = dac - mdl[8'hBD];
      chk(o_low_trip_code, (m < 0) ? 9'h000 : 9'(m));
      chk({o_bias_range, o_power_loop_range}, 9'(((mdl[8'hB9] >> 1) & 8'h38) | (mdl[8'hB9] & 7)));
    end
    up <= 1'b1;
    dac <= 8'h80;
    bus_wr(8'hB9, 8'h00);
    bus_wr(8'hBC, 8'h10);
    bus_wr(8'hBD, 8'h10);
    bus_wr(8'hF3, 8'h03);
    frc <= 9'h190;
    repeat (8) @(posedge i_clk);
    bus_rd(8'hF2, r);
    for (i = 0; i < 2; i++) begin
      frc <= i ? 9'h16F : 9'h191;
      repeat (8) @(posedge i_clk);
      chk({o_transmit_power_high_alarm, o_transmit_power_low_alarm, o_irq}, i ? 3'b011 : 3'b101);
      bus_rd(8'hF2, r);
      chk(r[1:0], i ? 2'b10 : 2'b01);
      frc <= 9'h190;
      repeat (8) @(posedge i_clk);
      bus_rd(8'hF2, r);
      repeat (2) @(posedge i_clk);
      chk({o_transmit_power_high_alarm, o_transmit_power_low_alarm, o_irq}, 3'b000);
    end
    frc <= 9'h191;
    bus_wr(8'hF3, 8'h00);
    repeat (8) @(posedge i_clk);
    chk(o_irq, 1'b0);
    frc <= 9'h000;
    dac <= 8'h64;
    bus_wr(8'hBB, 8'h08);
    for (i = 0; i < 2; i++) begin
      ceil <= i ? 9'h040 : 9'h1FF;
      bus_wr(8'hF0, i ? 8'h40 : 8'hFF);
      bus_wr(8'hF1, i ? 8'h00 : 8'h01);
      bus_rd(8'hF0, r);
      chk(r, i ? 9'h040 : 9'h0FF);
      bus_rd(8'hF2, r);
      i_tx_disable <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_tx_disable <= 1'b0;
      wait_busy(1'b1);
      wait_busy(1'b0);
      if (i) chk(o_bias_setting <= 9'h040, 1'b1);
      else chk(o_bias_setting >= 9'h0C4 && o_bias_setting <= 9'h0CC, 1'b1);
      bus_rd(8'hF2, r);
      chk(r[3], 1'b1);
      bus_rd(8'hF5, r);
      chk(r, 9'h010);
    end
    ceil <= 9'h000;
    repeat (8) @(posedge i_clk);
    chk(o_bias_max_alarm, 1'b1);
    i_tx_disable <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_tx_disable <= 1'b0;
    wait_busy(1'b1);
    repeat (10) @(posedge i_clk);
    chk(o_bias_max_alarm, 1'b0);
    wait_busy(1'b0);
    repeat (4) @(posedge i_clk);
    chk(o_bias_max_alarm, 1'b1);
    i_ce <= 1'b0;
    bus_wr(8'hBB, 8'h33);
    i_ce <= 1'b1;
    bus_rd(8'hBB, r);
    chk(r, 9'h008);
    complete_run();
  end
endmodule : lpl_trip_thresholds_tb_top
